//--- eil_irq_latch.sv
`timescale 1ns/100ps
// Summary of operation
// - a falling edge on the interrupt pin latches a request
// - a vector fetch acknowledges and clears the latch
// - writing one to the acknowledge bit acknowledges like a vector fetch
// - reset clears latch and sensitivity select even with pin low
// - falling edge by default; sensitivity select adds low level
// - edge-only: latch stays set until acknowledge or reset
// - edge-only: acknowledge clears at once, pin level ignored
// - edge plus level: clear needs acknowledge and pin high, either order
// - edge plus level: request pending while pin stays low
// - request reaches priority logic only while mask bit is clear
// - falling edge after a software acknowledge latches a new request
// - pending flag shows the latch regardless of the mask
// - acknowledge bit is write-only, reads zero, reset clears it
// - sensitivity select: one is edge plus level, zero edge only
// - in break, software acknowledge works only with break clear enabled
module eil_irq_latch (
    input  wire logic                           mclk,
    input  wire logic                           reset,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [eil_pkg::EIL_ADDR_W-1:0] paddr,
    input  wire logic [eil_pkg::EIL_DATA_W-1:0] pwdata,
    output logic      [eil_pkg::EIL_DATA_W-1:0] prdata,
    output logic                                pready,
    output logic                                pslverr,
    input  wire logic                           ext_irq_n,
    input  wire logic                           vector_fetch,
    input  wire logic                           break_state,
    output logic                                irq_request
);
    import eil_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // pin front end

    eil_pin_if pin_bus ();

    eil_pin_sync u_pin_sync (
        .mclk      (mclk),
        .reset     (reset),
        .ext_irq_n (ext_irq_n),
        .sync_out  (pin_bus)
    );

    ////////////////////////////////////////////////////////////////////////////
    // state

    logic sensitivity;
    logic request_mask_bit;
    logic break_clear_enable;
    logic latch;
    logic ack_seen;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic addr_is(input logic [EIL_ADDR_W-1:0] a,
                                     input logic [EIL_ADDR_W-1:0] ofs);
        addr_is = (a == ofs);
    endfunction

    function automatic logic [EIL_DATA_W-1:0] one_bit(input int pos, input logic v);
        logic [EIL_DATA_W-1:0] w;
        w      = '0;
        w[pos] = v;
        one_bit = w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // bus decode

    wire setup_phase = psel & ~penable;
    wire access_done = psel & penable & pready;
    wire hit_status  = addr_is(paddr, EIL_OFS_STATUS);
    wire hit_break   = addr_is(paddr, EIL_OFS_BREAK);
    wire mapped      = hit_status | hit_break;
    wire wr_status   = access_done & pwrite & hit_status;
    wire wr_break    = access_done & pwrite & hit_break;

    ////////////////////////////////////////////////////////////////////////////
    // acknowledge sources

    // the write bit itself is never stored, so it always reads zero
    wire sw_ack_req  = wr_status & pwdata[EIL_BIT_ACK];
    wire break_allow = ~break_state | break_clear_enable;
    wire sw_ack      = sw_ack_req & break_allow;
    wire ack         = vector_fetch | sw_ack;

    ////////////////////////////////////////////////////////////////////////////
    // latch logic

    wire pin_low     = ~pin_bus.pin_high;
    // level mode keeps re-setting while the pin is low
    wire set_evt     = pin_bus.fall | (sensitivity & pin_low);
    wire ack_any     = ack | ack_seen;
    wire clr_level   = ack_any & pin_bus.pin_high;
    wire clr_edge    = ack;
    wire clr_evt     = sensitivity ? clr_level : clr_edge;
    // set wins over clear, so an edge in the acknowledge cycle is kept
    wire next_latch  = set_evt ? 1'b1 : (clr_evt ? 1'b0 : latch);

    // remembers an acknowledge that came while the pin was still low
    wire next_ack_seen = sensitivity & next_latch & ~clr_evt & ack_any;

    wire next_sense  = wr_status ? pwdata[EIL_BIT_SENSE] : sensitivity;
    wire next_mask   = wr_status ? pwdata[EIL_BIT_MASK]  : request_mask_bit;
    wire next_bce    = wr_break  ? pwdata[EIL_BIT_BCE]   : break_clear_enable;

    // the pending flag ignores the mask so polling still works
    wire next_irq    = latch & ~request_mask_bit;

    ////////////////////////////////////////////////////////////////////////////
    // read data

    wire [EIL_DATA_W-1:0] rd_status = one_bit(EIL_BIT_SENSE, sensitivity)
                                    | one_bit(EIL_BIT_MASK,  request_mask_bit)
                                    | one_bit(EIL_BIT_PEND,  latch)
                                    | one_bit(EIL_BIT_PIN,   pin_bus.pin_high);
    wire [EIL_DATA_W-1:0] rd_break  = one_bit(EIL_BIT_BCE, break_clear_enable);
    wire [EIL_DATA_W-1:0] rd_sel    = hit_status ? rd_status :
                                      (hit_break ? rd_break : EIL_RST_RDATA);
    wire [EIL_DATA_W-1:0] next_rdata = (setup_phase & ~pwrite) ? rd_sel : EIL_RST_RDATA;

    // zero wait states: pready rises in the first access cycle
    wire next_ready  = setup_phase;
    wire next_err    = setup_phase & ~mapped;

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge mclk) begin
        if (reset) begin
            sensitivity        <= EIL_RST_SENSE;
            request_mask_bit   <= EIL_RST_MASK;
            break_clear_enable <= EIL_RST_BCE;
            latch              <= EIL_RST_LATCH;
            ack_seen           <= 1'b0;
        end else begin
            sensitivity        <= next_sense;
            request_mask_bit   <= next_mask;
            break_clear_enable <= next_bce;
            latch              <= next_latch;
            ack_seen           <= next_ack_seen;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            irq_request <= 1'b0;
            prdata      <= EIL_RST_RDATA;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
        end else begin
            irq_request <= next_irq;
            prdata      <= next_rdata;
            pready      <= next_ready;
            pslverr     <= next_err;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge mclk);
    endclocking

    default disable iff (reset);

    chk_fall_sets_latch: assert property (
        pin_bus.fall |=> latch)
        else $error("falling edge did not set the latch");

    chk_vector_clears: assert property (
        vector_fetch && !sensitivity && !pin_bus.fall |=> !latch)
        else $error("vector fetch did not clear the edge latch");

    chk_soft_ack_clears: assert property (
        sw_ack_req && !break_state && !sensitivity && !pin_bus.fall |=> !latch)
        else $error("software acknowledge did not clear the latch");

    chk_reset_clears: assert property (
        @(posedge mclk) disable iff (1'b0)
        reset |=> !latch && !sensitivity && !irq_request)
        else $error("reset left the latch or sensitivity set");

    chk_edge_holds: assert property (
        latch && !sensitivity && !ack |=> latch)
        else $error("edge latch dropped without acknowledge");

    chk_edge_ignores_pin: assert property (
        latch && !sensitivity && ack && pin_low && !pin_bus.fall |=> !latch)
        else $error("edge acknowledge waited for the pin");

    chk_level_clear: assert property (
        sensitivity && latch && ack_seen && pin_bus.pin_high && !ack |=> !latch)
        else $error("late pin release did not clear after earlier acknowledge");

    chk_level_pending: assert property (
        sensitivity && pin_low |=> latch)
        else $error("level request not pending while pin low");

    chk_mask_gate: assert property (
        irq_request |-> $past(latch) && !$past(request_mask_bit))
        else $error("request forwarded while masked or not latched");

    chk_new_edge_after_ack: assert property (
        sw_ack ##1 pin_bus.fall |=> latch)
        else $error("edge after acknowledge was lost");

    chk_pend_readback: assert property (
        setup_phase && hit_status && !pwrite |=> prdata[EIL_BIT_PEND] == $past(latch))
        else $error("pending flag does not show the latch");

    chk_ack_reads_zero: assert property (
        pready |-> !prdata[EIL_BIT_ACK])
        else $error("acknowledge bit read back as one");

    chk_break_protect: assert property (
        latch && !ack_seen && sw_ack_req && break_state && !break_clear_enable && !vector_fetch
        |=> latch)
        else $error("acknowledge during break cleared a protected latch");

    chk_edge_wins: assert property (
        pin_bus.fall && ack |=> latch)
        else $error("acknowledge beat a simultaneous edge");

    chk_edge_only_fall: assert property (
        !sensitivity && !latch && !pin_bus.fall |=> !latch)
        else $error("edge mode latched without a falling edge");

    chk_level_vector: assert property (
        vector_fetch && sensitivity && pin_bus.pin_high && !pin_bus.fall |=> !latch)
        else $error("level mode vector fetch with pin high did not clear");

    chk_level_ack_kept: assert property (
        sensitivity && ack && pin_low |=> latch && ack_seen)
        else $error("acknowledge while pin low was not remembered");

    chk_ack_seen_latched: assert property (
        ack_seen |-> latch)
        else $error("remembered acknowledge without a latched request");

    chk_irq_forward: assert property (
        latch && !request_mask_bit |=> irq_request)
        else $error("unmasked latch not forwarded");

    chk_mask_blocks: assert property (
        request_mask_bit |=> !irq_request)
        else $error("request forwarded while masked");

    chk_mask_write: assert property (
        wr_status |=> request_mask_bit == $past(pwdata[EIL_BIT_MASK]))
        else $error("mask bit write did not land");

    chk_sense_write: assert property (
        wr_status |=> sensitivity == $past(pwdata[EIL_BIT_SENSE]))
        else $error("sensitivity select write did not land");

    chk_break_allows: assert property (
        sw_ack_req && break_state && break_clear_enable && !sensitivity && !pin_bus.fall
        |=> !latch)
        else $error("enabled acknowledge during break did not clear");

    chk_pin_readback: assert property (
        setup_phase && hit_status && !pwrite |=> prdata[EIL_BIT_PIN] == $past(pin_bus.pin_high))
        else $error("pin level readback wrong");

    chk_bce_readback: assert property (
        setup_phase && hit_break && !pwrite
        |=> prdata[EIL_BIT_BCE] == $past(break_clear_enable))
        else $error("break clear enable readback wrong");

    chk_ready_after_setup: assert property (
        setup_phase |=> pready)
        else $error("no ready after setup cycle");

    chk_ready_single: assert property (
        pready |=> !pready)
        else $error("ready held for more than one cycle");

    chk_err_unmapped: assert property (
        setup_phase && !mapped |=> pslverr && pready)
        else $error("unmapped access without error");

    chk_err_mapped: assert property (
        setup_phase && mapped |=> !pslverr)
        else $error("error on a mapped access");

    chk_write_reads_zero: assert property (
        pready && pwrite |-> prdata == '0)
        else $error("read data not zero on a write");

    chk_unmapped_ignored: assert property (
        access_done && pwrite && !mapped
        |=> $stable(sensitivity) && $stable(request_mask_bit) && $stable(break_clear_enable))
        else $error("unmapped write changed a register");

endmodule

//--- eil_pin_if.sv
`timescale 1ns/100ps
interface eil_pin_if;
    logic pin_high;
    logic fall;

    modport src (
        output pin_high,
        output fall
    );
    modport dst (
        input  pin_high,
        input  fall
    );
endinterface

//--- eil_pin_sync.sv
`timescale 1ns/100ps
module eil_pin_sync (
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic ext_irq_n,
    eil_pin_if.src    sync_out
);
    import eil_pkg::*;

    logic meta;
    logic samp_a;
    logic samp_b;
    logic stable;
    logic fall;

    ////////////////////////////////////////////////////////////////////////////
    // a change is accepted only once the second and third stages agree,
    // which also filters single-cycle glitches
    wire agree      = samp_a == samp_b;
    wire next_fall  = agree & ~samp_b & stable;

    always_ff @(posedge mclk) begin
        if (reset) begin
            // keep sampling through reset: a pin already held low must not
            // look like a fresh falling edge once reset lets go
            meta   <= ext_irq_n;
            samp_a <= meta;
            samp_b <= samp_a;
            stable <= samp_b;
            fall   <= 1'b0;
        end else begin
            meta   <= ext_irq_n;
            samp_a <= meta;
            samp_b <= samp_a;
            stable <= agree ? samp_b : stable;
            fall   <= next_fall;
        end
    end

    assign sync_out.pin_high = stable;
    assign sync_out.fall     = fall;

    ////////////////////////////////////////////////////////////////////////////
    chk_fall_one_cycle: assert property (
        @(posedge mclk) disable iff (reset) fall |=> !fall)
        else $error("falling edge pulse lasted more than one cycle");

    chk_fall_to_low: assert property (
        @(posedge mclk) disable iff (reset) fall |-> !stable && $past(stable))
        else $error("falling edge pulse without a high to low transition");

endmodule

//--- eil_pkg.sv
package eil_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // bus geometry
    localparam int          EIL_ADDR_W      = 8;
    localparam int          EIL_DATA_W      = 32;

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0]  EIL_OFS_STATUS  = 8'h00;  // ext_int_status_control
    localparam logic [7:0]  EIL_OFS_BREAK   = 8'h04;  // break control

    ////////////////////////////////////////////////////////////////////////////
    // field positions of ext_int_status_control
    localparam int          EIL_BIT_SENSE   = 0;      // 1 = falling edge plus low level
    localparam int          EIL_BIT_MASK    = 1;      // request_mask_bit
    localparam int          EIL_BIT_ACK     = 2;      // write-only acknowledge
    localparam int          EIL_BIT_PEND    = 3;      // pending_flag, read-only
    localparam int          EIL_BIT_PIN     = 4;      // synchronised pin level, read-only

    // field position of the break control register
    localparam int          EIL_BIT_BCE     = 0;      // break_clear_enable

    ////////////////////////////////////////////////////////////////////////////
    // values after reset
    localparam logic        EIL_RST_SENSE   = 1'b0;
    localparam logic        EIL_RST_MASK    = 1'b0;
    localparam logic        EIL_RST_LATCH   = 1'b0;
    localparam logic        EIL_RST_BCE     = 1'b0;
    localparam logic        EIL_RST_PIN     = 1'b1;   // idle level of the active-low pin
    localparam logic [31:0] EIL_RST_RDATA   = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // slave answer timing: cycles from setup edge to pready
    localparam int          EIL_ANSWER_CYC  = 1;

endpackage

//--- eil_src_model.sv
`timescale 1ns/100ps
module eil_src_model (
    input  wire logic mclk,
    input  wire logic irq_request,
    output logic      ext_irq_n,
    output logic      vector_fetch
);
    // global cpu mask kept clear; setting it would delay every fetch until the 100-cycle wait runs out
    logic cpu_i_mask = 1'b0;

    initial begin
        ext_irq_n    = 1'b1;  // pull-up keeps the pin high while released
        vector_fetch = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic set_pin(input logic lvl);
        @(posedge mclk);
        ext_irq_n <= lvl;
    endtask

    // dly lets the cpu answer promptly or slowly
    task automatic take_vector(input int dly);
        int n;
        n = 0;
        while (!(irq_request === 1'b1 && !cpu_i_mask) && n < 100) begin
            @(posedge mclk);
            n++;
        end
        repeat (dly) @(posedge mclk);
        @(posedge mclk);
        vector_fetch <= 1'b1;
        @(posedge mclk);
        vector_fetch <= 1'b0;
    endtask
endmodule

//--- tb.sv
`timescale 1ns/100ps
module tb;
    import eil_pkg::*;
    logic        mclk, reset, psel, penable, pwrite, break_state;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rnd;
    logic        pready, pslverr, irq_request, ext_irq_n, vector_fetch;
    logic [33:0] exq[$];
    logic [33:0] got, exp_v;
    int          n_errors, n_tests;

    eil_irq_latch u_eil_irq_latch (.mclk(mclk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_irq_n(ext_irq_n),
        .vector_fetch(vector_fetch), .break_state(break_state),
        .irq_request(irq_request));
    eil_src_model u_eil_src_model (.mclk(mclk), .irq_request(irq_request),
        .ext_irq_n(ext_irq_n), .vector_fetch(vector_fetch));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // {pslverr, irq_request, prdata} of a status read
    function automatic logic [33:0] st(input logic s, m, p, pin);
        return {1'b0, p & ~m, 27'h0, pin, p, 1'b0, m, s};
    endfunction

    task automatic pause(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        exq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    // unused upper bits of the status word get random filler
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        rnd = lfsr(rnd);
        apb(1'b1, a, (a == EIL_OFS_STATUS) ? (d | (rnd & 32'hffff_ffe0)) : d);
    endtask
    task automatic pulse(input int n);
        u_eil_src_model.set_pin(1'b0);
        pause(n);
        u_eil_src_model.set_pin(1'b1);
        pause(10);
    endtask
    task automatic note(input string s);
        $display("test %s done", s);
    endtask
    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // read results are checked here, oldest expected value first
    always @(posedge mclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && exq.size() > 0) begin
            got   = {pslverr, irq_request, prdata};
            exp_v = exq.pop_front();
            n_tests++;
            if (got !== exp_v) begin
                $display("[ERR] t=%0t exp=%h got=%h", $time, exp_v, got);
                n_errors++;
            end
        end
    end

    initial begin
        pause(20000);
        n_errors++;
        complete_run;
    end

    initial begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        break_state = 1'b0;
        rnd = 32'ha75c;
        n_errors = 0;
        n_tests = 0;
        pause(16);
        reset <= 1'b0;
        pause(2);
        rd(EIL_OFS_STATUS, st(0, 0, 0, 1));
        rd(EIL_OFS_BREAK, 34'h0);
        rd(8'h08, {1'b1, 33'h0});
        wr(EIL_OFS_STATUS, 32'h4);
        rd(EIL_OFS_STATUS, st(0, 0, 0, 1));
        note("reset values");
        rnd = lfsr(rnd);
        pulse(3 + int'(rnd[2:0]));
        rd(EIL_OFS_STATUS, st(0, 0, 1, 1));
        u_eil_src_model.set_pin(1'b0);
        pause(10);
        u_eil_src_model.take_vector(0);
        pause(2);
        rd(EIL_OFS_STATUS, st(0, 0, 0, 0));
        u_eil_src_model.set_pin(1'b1);
        pause(10);
        note("edge mode");
        pulse(4);
        wr(EIL_OFS_STATUS, 32'h4);
        rd(EIL_OFS_STATUS, st(0, 0, 0, 1));
        pulse(4);
        rd(EIL_OFS_STATUS, st(0, 0, 1, 1));
        wr(EIL_OFS_STATUS, 32'h2);
        rd(EIL_OFS_STATUS, st(0, 1, 1, 1));
        wr(EIL_OFS_STATUS, 32'h0);
        rd(EIL_OFS_STATUS, st(0, 0, 1, 1));
        wr(EIL_OFS_STATUS, 32'h4);
        note("ack and mask");
        wr(EIL_OFS_STATUS, 32'h1);
        u_eil_src_model.set_pin(1'b0);
        pause(10);
        rd(EIL_OFS_STATUS, st(1, 0, 1, 0));
        wr(EIL_OFS_STATUS, 32'h7);
        rd(EIL_OFS_STATUS, st(1, 1, 1, 0));
        u_eil_src_model.set_pin(1'b1);
        pause(10);
        rd(EIL_OFS_STATUS, st(1, 1, 0, 1));
        wr(EIL_OFS_STATUS, 32'h1);
        pulse(4);
        rd(EIL_OFS_STATUS, st(1, 0, 1, 1));
        u_eil_src_model.take_vector(3);
        pause(2);
        rd(EIL_OFS_STATUS, st(1, 0, 0, 1));
        note("level mode");
        wr(EIL_OFS_STATUS, 32'h0);
        break_state <= 1'b1;
        pulse(4);
        wr(EIL_OFS_STATUS, 32'h4);
        rd(EIL_OFS_STATUS, st(0, 0, 1, 1));
        wr(EIL_OFS_BREAK, 32'h1);
        wr(EIL_OFS_STATUS, 32'h4);
        break_state <= 1'b0;
        pause(2);
        rd(EIL_OFS_STATUS, st(0, 0, 0, 1));
        rd(EIL_OFS_BREAK, 34'h1);
        note("break");
        wr(EIL_OFS_STATUS, 32'h1);
        u_eil_src_model.set_pin(1'b0);
        pause(10);
        reset <= 1'b1;
        pause(3);
        reset <= 1'b0;
        pause(10);
        rd(EIL_OFS_STATUS, st(0, 0, 0, 0));
        u_eil_src_model.set_pin(1'b1);
        note("reset with pin low");
        pause(4);
        complete_run;
    end
endmodule
